// file: rtl/card_host.sv
// Host controller that drives the card's memory and True IDE pins.
// Operation
// - Output enable held low across power-up selects IDE.
// - Fast timing only if all cards support it.
// - No fast timing: shared lines or long cable.
// - Stream via 8, 0, 8-9; never repeat 9.
`timescale 1ns/1ps
`include "card_host_regs.svh"
module card_host
   import card_host_pkg::*;
#(
   parameter int POWERUP_CYCLES = `POWERUP_CYC
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic power_request,
   input wire logic ide_select,
   input wire logic fast_timing_req,
   input wire logic all_cards_fast,
   input wire logic shared_master_slave,
   input wire logic long_cable,
   input wire logic req,
   input wire tgt_t req_target,
   input wire op_t req_op,
   input wire logic req_write,
   input wire logic req_stream,
   input wire logic [10:0] req_addr,
   input wire logic [15:0] req_wdata,
   output logic ready,
   output logic done,
   output logic req_error,
   output logic [15:0] rdata,
   output logic card_power_en,
   output logic ide_mode,
   output logic eight_bit_mode,
   output logic fast_active,
   input wire logic card_present,
   output logic space_select_n,
   output logic low_byte_chip_enable_n,
   output logic high_byte_chip_enable_n,
   output logic output_enable_n,
   output logic write_enable_n,
   output logic io_read_strobe_n,
   output logic io_write_strobe_n,
   output logic command_block_select_n,
   output logic control_block_select_n,
   output logic dma_acknowledge_n,
   output logic [10:0] card_addr,
   output logic [15:0] card_data_out,
   output logic card_data_oe_lo,
   output logic card_data_oe_hi,
   input wire logic [15:0] card_data_in
);
   state_t state_reg, state_next;
   logic [7:0] cnt_reg, cnt_next;
   logic [31:0] pwr_reg, pwr_next;
   logic strap_reg, strap_next, ide_reg, ide_next, eight_reg, eight_next, fast_reg, fast_next;
   logic done_reg, done_next, err_reg, err_next, last9_reg, last9_next, wr_reg, wr_next;
   logic ce_lo_reg, ce_lo_next, ce_hi_reg, ce_hi_next, oe_n_reg, oe_n_next;
   logic we_n_reg, we_n_next, io_read_strobe_n_reg, io_read_strobe_n_next, io_write_strobe_n_reg, io_write_strobe_n_next;
   logic cs0_reg, cs0_next, cs1_reg, cs1_next, dma_acknowledge_n_reg, dma_acknowledge_n_next;
   logic dlo_reg, dlo_next, dhi_reg, dhi_next;
   logic [1:0] op_reg, op_next;
   logic [7:0] feat_reg, feat_next;
   logic [9:0] win_reg, win_next;
   logic [10:0] addr_reg, addr_next;
   logic [15:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
   logic [15:0] din_s1, din_s2;
   logic pres_s1, pres_s2, pres_s3;
   logic hits9, bad, ide_data;
   op_t op_e;
   logic [10:0] addr_e;

   // Pins from the card pass two flops before anything looks at them.
   always_ff @(posedge mclk) begin
      din_s1 <= card_data_in;
      din_s2 <= din_s1;
      pres_s1 <= card_present;
      pres_s2 <= pres_s1;
      pres_s3 <= pres_s2;
   end

   always_comb begin
      addr_e = (req_stream && req_target == TGT_MEM) ? (`DATA_WINDOW_BASE | {1'b0, win_reg}) : req_addr;
      hits9 = addr_e[10] ? addr_e[0] : (addr_e[3:0] == `OFF_DUP_ODD);
      ide_data = req_target == TGT_DMA || (req_target == TGT_CMD && req_addr[2:0] == 3'h0);
      if (ide_reg && ide_data) begin
         op_e = eight_reg ? OP_LOW : OP_WORD;
      end else if (ide_reg) begin
         op_e = OP_LOW;
      end else begin
         op_e = req_op;
      end
      if (ide_reg) begin
         bad = req_target == TGT_MEM || (req_target == TGT_CMD && req_op == OP_HIGH)
            || (req_target == TGT_CTRL && (req_addr[2:1] != 2'h3
            || (req_addr[2:0] == `IDE_DRIVE_ADDR && req_write)));
      end else begin
         // Only the memory mapped configuration is driven from here.
         bad = req_target != TGT_MEM || (last9_reg && req_op == OP_LOW && hits9);
      end
   end

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      pwr_next = pwr_reg;
      strap_next = strap_reg;
      ide_next = ide_reg;
      eight_next = eight_reg;
      fast_next = fast_timing_req && all_cards_fast && !shared_master_slave && !long_cable;
      done_next = 1'b0;
      err_next = 1'b0;
      last9_next = last9_reg;
      wr_next = wr_reg;
      ce_lo_next = ce_lo_reg;
      ce_hi_next = ce_hi_reg;
      oe_n_next = 1'b1;
      we_n_next = 1'b1;
      io_read_strobe_n_next = 1'b1;
      io_write_strobe_n_next = 1'b1;
      cs0_next = cs0_reg;
      cs1_next = cs1_reg;
      dma_acknowledge_n_next = dma_acknowledge_n_reg;
      dlo_next = dlo_reg;
      dhi_next = dhi_reg;
      op_next = op_reg;
      feat_next = feat_reg;
      win_next = win_reg;
      addr_next = addr_reg;
      wdata_next = wdata_reg;
      rdata_next = rdata_reg;
      case (state_reg)
         ST_OFF: begin
            ide_next = 1'b0;
            eight_next = 1'b0;
            oe_n_next = !ide_select;
            if (power_request) begin
               strap_next = ide_select;
               pwr_next = 32'h0000_0000;
               state_next = ST_RAMP;
            end
         end
         ST_RAMP: begin
            oe_n_next = !strap_reg;
            pwr_next = pwr_reg + 32'h0000_0001;
            if (pwr_reg == 32'(POWERUP_CYCLES - 1)) begin
               // The strap is let go as power-up ends, so no read strobe is left behind in IDE.
               oe_n_next = 1'b1;
               ide_next = strap_reg;
               state_next = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (req && bad) begin
               err_next = 1'b1;
            end else if (req) begin
               op_next = op_e;
               wr_next = req_write;
               addr_next = addr_e;
               last9_next = !ide_reg && req_op == OP_LOW && hits9;
               if (req_stream && !ide_reg) begin
                  win_next = win_reg + ((req_op == OP_WORD) ? 10'h002 : 10'h001);
               end
               ce_lo_next = ide_reg || op_e == OP_HIGH;
               ce_hi_next = ide_reg || op_e == OP_LOW;
               cs0_next = !(ide_reg && req_target == TGT_CMD);
               cs1_next = !(ide_reg && req_target == TGT_CTRL);
               dma_acknowledge_n_next = !(ide_reg && req_target == TGT_DMA);
               dlo_next = req_write && op_e != OP_HIGH;
               dhi_next = req_write && op_e != OP_LOW;
               wdata_next = (op_e == OP_HIGH) ? {req_wdata[7:0], 8'h00} : req_wdata;
               if (ide_reg && req_write && req_target == TGT_CMD) begin
                  if (req_addr[2:0] == 3'(`OFF_ERROR_FEATURE)) begin
                     feat_next = req_wdata[7:0];
                  end
                  if (req_addr[2:0] == 3'(`OFF_STATUS_COMMAND)
                     && req_wdata[7:0] == `CMD_SET_FEATURES) begin
                     if (feat_reg == `FEAT_8BIT_ON) begin
                        eight_next = 1'b1;
                     end else if (feat_reg == `FEAT_8BIT_OFF) begin
                        eight_next = 1'b0;
                     end
                  end
               end
               cnt_next = 8'(`SETUP_CYC - 1);
               state_next = ST_SETUP;
            end
         end
         ST_SETUP: begin
            cnt_next = cnt_reg - 8'h01;
            if (cnt_reg == 8'h00) begin
               cnt_next = fast_reg ? 8'(`FAST_STROBE_CYC - 1) : 8'(`SLOW_STROBE_CYC - 1);
               state_next = ST_STROBE;
            end
         end
         ST_STROBE: begin
            oe_n_next = ide_reg || wr_reg;
            we_n_next = ide_reg || !wr_reg;
            io_read_strobe_n_next = !ide_reg || wr_reg;
            io_write_strobe_n_next = !ide_reg || !wr_reg;
            cnt_next = cnt_reg - 8'h01;
            if (cnt_reg == 8'h00) begin
               oe_n_next = 1'b1;
               we_n_next = 1'b1;
               io_read_strobe_n_next = 1'b1;
               io_write_strobe_n_next = 1'b1;
               case (op_reg)
                  OP_LOW: rdata_next = {8'h00, din_s2[7:0]};
                  OP_HIGH: rdata_next = {8'h00, din_s2[15:8]};
                  default: rdata_next = din_s2;
               endcase
               cnt_next = 8'(`HOLD_CYC - 1);
               state_next = ST_HOLD;
            end
         end
         ST_HOLD: begin
            cnt_next = cnt_reg - 8'h01;
            if (cnt_reg == 8'h00) begin
               ce_lo_next = 1'b1;
               ce_hi_next = 1'b1;
               cs0_next = 1'b1;
               cs1_next = 1'b1;
               dma_acknowledge_n_next = 1'b1;
               dlo_next = 1'b0;
               dhi_next = 1'b0;
               done_next = 1'b1;
               state_next = ST_IDLE;
            end
         end
         default: state_next = ST_OFF;
      endcase
      // A card inserted after power-up starts in card mode, whatever the strap said earlier.
      if (pres_s2 && !pres_s3 && state_reg != ST_OFF) begin
         ide_next = 1'b0;
         eight_next = 1'b0;
      end
      if (!power_request) begin
         state_next = ST_OFF;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         state_reg <= ST_OFF;
         cnt_reg <= 8'h00;
         pwr_reg <= 32'h0000_0000;
         {strap_reg, ide_reg, eight_reg, fast_reg, done_reg, err_reg, last9_reg, wr_reg} <= 8'h00;
         {ce_lo_reg, ce_hi_reg, oe_n_reg, we_n_reg, io_read_strobe_n_reg, io_write_strobe_n_reg} <= 6'h3f;
         {cs0_reg, cs1_reg, dma_acknowledge_n_reg, dlo_reg, dhi_reg} <= 5'h1c;
         op_reg <= 2'h0;
         feat_reg <= 8'h00;
         win_reg <= 10'h000;
         addr_reg <= 11'h000;
         wdata_reg <= 16'h0000;
         rdata_reg <= 16'h0000;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         pwr_reg <= pwr_next;
         {strap_reg, ide_reg, eight_reg, fast_reg} <= {strap_next, ide_next, eight_next, fast_next};
         {done_reg, err_reg, last9_reg, wr_reg} <= {done_next, err_next, last9_next, wr_next};
         {ce_lo_reg, ce_hi_reg, oe_n_reg} <= {ce_lo_next, ce_hi_next, oe_n_next};
         {we_n_reg, io_read_strobe_n_reg, io_write_strobe_n_reg} <= {we_n_next, io_read_strobe_n_next, io_write_strobe_n_next};
         {cs0_reg, cs1_reg, dma_acknowledge_n_reg, dlo_reg, dhi_reg} <=
            {cs0_next, cs1_next, dma_acknowledge_n_next, dlo_next, dhi_next};
         op_reg <= op_next;
         feat_reg <= feat_next;
         win_reg <= win_next;
         addr_reg <= addr_next;
         wdata_reg <= wdata_next;
         rdata_reg <= rdata_next;
      end
   end

   assign ready = state_reg == ST_IDLE;
   assign done = done_reg;
   assign req_error = err_reg;
   assign rdata = rdata_reg;
   assign card_power_en = state_reg != ST_OFF;
   assign ide_mode = ide_reg;
   assign eight_bit_mode = eight_reg;
   assign fast_active = fast_reg;
   assign space_select_n = 1'b1;
   assign low_byte_chip_enable_n = ce_lo_reg;
   assign high_byte_chip_enable_n = ce_hi_reg;
   assign output_enable_n = oe_n_reg;
   assign write_enable_n = we_n_reg;
   assign io_read_strobe_n = io_read_strobe_n_reg;
   assign io_write_strobe_n = io_write_strobe_n_reg;
   assign command_block_select_n = cs0_reg;
   assign control_block_select_n = cs1_reg;
   assign dma_acknowledge_n = dma_acknowledge_n_reg;
   assign card_addr = addr_reg;
   assign card_data_out = wdata_reg;
   assign card_data_oe_lo = dlo_reg;
   assign card_data_oe_hi = dhi_reg;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   sequence s_accept;
      state_reg == ST_IDLE && req && !bad && power_request;
   endsequence
   sequence s_setup_run;
      (state_reg == ST_SETUP) [*8] ##1 state_reg == ST_STROBE;
   endsequence
   property p_no_dual_select;
      !(!cs0_reg && !cs1_reg) && !(!dma_acknowledge_n_reg && (!cs0_reg || !cs1_reg));
   endproperty
   a_no_dual_select: assert property (p_no_dual_select) else $error("two selects at once");
   property p_ide_no_memory;
      ide_reg |-> oe_n_reg && we_n_reg && ce_lo_reg && ce_hi_reg;
   endproperty
   a_ide_no_memory: assert property (p_ide_no_memory) else $error("memory cycle in IDE");
   property p_strap_held;
      state_reg == ST_RAMP && strap_reg |-> !oe_n_reg;
   endproperty
   a_strap_held: assert property (p_strap_held) else $error("strap released in ramp");
   property p_word_lanes;
      state_reg == ST_STROBE && !ce_lo_reg && !ce_hi_reg && !we_n_reg |-> dlo_reg && dhi_reg;
   endproperty
   a_word_lanes: assert property (p_word_lanes) else $error("word write lane missing");
   property p_low_lane;
      !ce_lo_reg && ce_hi_reg |-> !dhi_reg;
   endproperty
   a_low_lane: assert property (p_low_lane) else $error("upper lane driven on byte");
   property p_high_lane;
      ce_lo_reg && !ce_hi_reg |-> !dlo_reg;
   endproperty
   a_high_lane: assert property (p_high_lane) else $error("lower lane driven on odd");
   property p_no_repeat9;
      state_reg == ST_IDLE && req && power_request && !ide_reg && last9_reg
         && req_op == OP_LOW && hits9 |=> req_error && state_reg != ST_SETUP;
   endproperty
   a_no_repeat9: assert property (p_no_repeat9) else $error("repeat byte 9 taken");
   property p_window;
      s_accept ##0 (req_stream && !ide_reg) |=> card_addr[10];
   endproperty
   a_window: assert property (p_window) else $error("stream outside window");
   property p_setup_time;
      s_accept |=> s_setup_run;
   endproperty
   a_setup_time: assert property (p_setup_time) else $error("setup length wrong");
   property p_reinsert;
      $rose(pres_s2) && state_reg != ST_OFF |=> !ide_reg;
   endproperty
   a_reinsert: assert property (p_reinsert) else $error("IDE kept on reinsert");
   property p_fast_gate;
      fast_reg |-> $past(all_cards_fast && !shared_master_slave && !long_cable);
   endproperty
   a_fast_gate: assert property (p_fast_gate) else $error("fast timing not allowed");
endmodule

// file: rtl/card_host_pkg.sv
// Types shared by the card host controller.
package card_host_pkg;
   typedef enum logic [2:0] {
      ST_OFF = 3'h0, ST_RAMP = 3'h1, ST_IDLE = 3'h3,
      ST_SETUP = 3'h2, ST_STROBE = 3'h6, ST_HOLD = 3'h7
   } state_t;
   typedef enum logic [1:0] {OP_WORD = 2'h0, OP_LOW = 2'h1, OP_HIGH = 2'h2} op_t;
   typedef enum logic [1:0] {TGT_MEM = 2'h0, TGT_CMD = 2'h1, TGT_CTRL = 2'h2,
      TGT_DMA = 2'h3} tgt_t;
endpackage

// file: rtl/card_host_regs.svh
// Offsets, field values and timing counts for the card host controller.
`ifndef CARD_HOST_REGS_SVH
`define CARD_HOST_REGS_SVH
`define CLK_PERIOD_NS 4
`define SETUP_NS 30
`define SETUP_CYC ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SLOW_STROBE_NS 165
`define SLOW_STROBE_CYC ((`SLOW_STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FAST_STROBE_NS 80
`define FAST_STROBE_CYC ((`FAST_STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_NS 20
`define HOLD_CYC ((`HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POWERUP_US 100
`define POWERUP_CYC (`POWERUP_US * 1000 / `CLK_PERIOD_NS)
`define OFF_EVEN_DATA 4'h0
`define OFF_ERROR_FEATURE 4'h1
`define OFF_SECTOR_COUNT 4'h2
`define OFF_SECTOR_NUMBER 4'h3
`define OFF_CYLINDER_LOW 4'h4
`define OFF_CYLINDER_HIGH 4'h5
`define OFF_CARD_HEAD 4'h6
`define OFF_STATUS_COMMAND 4'h7
`define OFF_DUP_EVEN 4'h8
`define OFF_DUP_ODD 4'h9
`define OFF_DUP_ERROR 4'hd
`define OFF_ALT_STATUS 4'he
`define OFF_DRIVE_ADDR 4'hf
`define IDE_ALT_STATUS 3'h6
`define IDE_DRIVE_ADDR 3'h7
`define DATA_WINDOW_BASE 11'h400
`define CMD_SET_FEATURES 8'hef
`define FEAT_8BIT_ON 8'h01
`define FEAT_8BIT_OFF 8'h81
`endif

// file: verification/card_device_model.sv
// Behavioural card that answers the host controller's memory and True IDE cycles.
`timescale 1ns/1ps
`include "card_host_regs.svh"
module card_device_model (
   input wire logic mclk,
   input wire logic card_power_en,
   input wire logic low_byte_chip_enable_n,
   input wire logic high_byte_chip_enable_n,
   input wire logic output_enable_n,
   input wire logic write_enable_n,
   input wire logic io_read_strobe_n,
   input wire logic io_write_strobe_n,
   input wire logic command_block_select_n,
   input wire logic control_block_select_n,
   input wire logic dma_acknowledge_n,
   input wire logic [10:0] card_addr,
   input wire logic [15:0] card_data_out,
   output logic [15:0] card_data_in
);
   logic ide_reg = 1'b0, eight_reg = 1'b0, pwr_reg = 1'b0, rd_q = 1'b0, wr_q = 1'b0;
   logic rd, wr, lo, hi, dat;
   logic [3:0] off, idx;
   logic [7:0] regs [16];
   logic [7:0] ptr = 8'h00;
   logic [15:0] last = 16'h0000, wr_word, val;
   always_comb begin
      lo = !low_byte_chip_enable_n;
      hi = !high_byte_chip_enable_n;
      rd = !output_enable_n && (lo || hi);
      wr = !write_enable_n && (lo || hi);
      off = card_addr[10] ? {3'h4, card_addr[0]} : card_addr[3:0];
      if (ide_reg) begin
         rd = !io_read_strobe_n;
         wr = !io_write_strobe_n;
         off = {!control_block_select_n, card_addr[2:0]};
         if (!dma_acknowledge_n) off = 4'h0;
         lo = 1'b1;
         hi = !eight_reg && off == 4'h0;
         if (!command_block_select_n && !control_block_select_n) {rd, wr} = 2'h0;
         if (!dma_acknowledge_n && !(command_block_select_n && control_block_select_n)) begin
            {rd, wr} = 2'h0;
         end
      end
      dat = lo && (off == 4'h0 || off[3:1] == 3'h4);
      idx = (off == 4'h0 || off == 4'hd) ? 4'h1 : off;
      val = dat ? {ptr + 8'h41, ptr + 8'h40} : {regs[idx], regs[idx]};
      // Released lanes toggle so a stale value can never pass for real data.
      card_data_in[15:8] = rd && hi ? val[15:8] : ~last[15:8];
      card_data_in[7:0] = rd && lo ? val[7:0] : ~last[7:0];
   end
   always @(posedge mclk) begin
      pwr_reg <= card_power_en;
      rd_q <= rd;
      wr_q <= wr;
      last <= card_data_in;
      if (card_power_en && !pwr_reg) begin
         ide_reg <= !output_enable_n;
         eight_reg <= 1'b0;
      end
      if (rd_q && !rd && dat) ptr <= ptr + (hi ? 8'h02 : 8'h01);
      if (wr_q && !wr) begin
         if (dat) wr_word <= card_data_out;
         else regs[idx] <= hi && !lo ? card_data_out[15:8] : card_data_out[7:0];
         if (ide_reg && off == 4'h7 && card_data_out[7:0] == `CMD_SET_FEATURES) begin
            eight_reg <= regs[1] == `FEAT_8BIT_ON;
         end
      end
   end
endmodule

// file: verification/card_host_test.sv
// Self-checking bench for the card host controller against a behavioural card.
`timescale 1ns/1ps
`include "card_host_regs.svh"
module card_host_test import card_host_pkg::*;;
   logic mclk, reset, power_request, ide_select, fast_timing_req, all_cards_fast;
   logic shared_master_slave, long_cable, req, req_write, req_stream, card_present, err;
   tgt_t req_target;
   op_t req_op;
   logic [10:0] req_addr, card_addr;
   logic [15:0] req_wdata, rdata, card_data_out, card_data_in;
   logic ready, done, req_error, card_power_en, ide_mode, eight_bit_mode, fast_active;
   logic low_byte_chip_enable_n, high_byte_chip_enable_n, output_enable_n, write_enable_n;
   logic io_read_strobe_n, io_write_strobe_n, command_block_select_n, control_block_select_n;
   logic dma_acknowledge_n, card_data_oe_lo, card_data_oe_hi;
   int mismatches = 0, checks = 0;
   card_host #(.POWERUP_CYCLES(10)) dut_u (.mclk, .reset, .power_request, .ide_select,
      .fast_timing_req, .all_cards_fast, .shared_master_slave, .long_cable, .req, .req_target,
      .req_op, .req_write, .req_stream, .req_addr, .req_wdata, .ready, .done, .req_error,
      .rdata, .card_power_en, .ide_mode, .eight_bit_mode, .fast_active, .card_present,
      .space_select_n(), .low_byte_chip_enable_n, .high_byte_chip_enable_n, .output_enable_n,
      .write_enable_n, .io_read_strobe_n, .io_write_strobe_n, .command_block_select_n,
      .control_block_select_n, .dma_acknowledge_n, .card_addr, .card_data_out,
      .card_data_oe_lo, .card_data_oe_hi, .card_data_in);
   card_device_model model_u (.mclk, .card_power_en, .low_byte_chip_enable_n,
      .high_byte_chip_enable_n, .output_enable_n, .write_enable_n, .io_read_strobe_n,
      .io_write_strobe_n, .command_block_select_n, .control_block_select_n,
      .dma_acknowledge_n, .card_addr, .card_data_out, .card_data_in);
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One request at a time; the next waits until ready returns after done.
   task automatic xfer(input tgt_t t, input op_t o, input logic w, input logic [10:0] a,
         input logic [15:0] d);
      int n;
      n = 0;
      while (ready !== 1'b1 && n < 500) begin
         @(posedge mclk);
         #1 n++;
      end
      // A controller that never comes back to idle counts as a mismatch.
      if (n >= 500) cmp({15'h0000, ready}, 16'h0001);
      req_target = t;
      req_op = o;
      req_write = w;
      req_addr = a;
      req_wdata = d;
      req = 1'b1;
      @(posedge mclk);
      #1 req = 1'b0;
      n = 0;
      while (done !== 1'b1 && req_error !== 1'b1 && n < 200) begin
         @(posedge mclk);
         #1 n++;
      end
      if (n >= 200) cmp({15'h0000, done}, 16'h0001);
      err = req_error;
      @(posedge mclk);
      #1;
   endtask
   task automatic rdchk(input tgt_t t, input op_t o, input logic [10:0] a,
         input logic [15:0] e);
      xfer(t, o, 1'b0, a, 16'h0000);
      cmp(rdata, e);
   endtask
   task automatic refuse(input tgt_t t, input op_t o, input logic w, input logic [10:0] a);
      xfer(t, o, w, a, 16'h0000);
      cmp({15'h0000, err}, 16'h0001);
   endtask
   initial begin
      #40000;
      mismatches++;
      end_of_test();
   end
   initial begin
      {reset, power_request, ide_select, fast_timing_req, all_cards_fast} = 5'h10;
      {shared_master_slave, long_cable, req, req_write, req_stream, card_present} = 6'h01;
      {req_addr, req_wdata} = 27'h000_0000;
      req_target = TGT_MEM;
      req_op = OP_WORD;
      repeat (16) @(posedge mclk);
      #1 reset = 1'b0;
      power_request = 1'b1;
      rdchk(TGT_MEM, OP_WORD, 11'h000, 16'h4140);
      rdchk(TGT_MEM, OP_LOW, 11'h000, 16'h0042);
      rdchk(TGT_MEM, OP_LOW, 11'h000, 16'h0043);
      rdchk(TGT_MEM, OP_LOW, 11'h008, 16'h0044);
      rdchk(TGT_MEM, OP_LOW, 11'h009, 16'h0045);
      refuse(TGT_MEM, OP_LOW, 1'b0, 11'h009);
      rdchk(TGT_MEM, OP_WORD, 11'h008, 16'h4746);
      rdchk(TGT_MEM, OP_WORD, 11'h400, 16'h4948);
      rdchk(TGT_MEM, OP_LOW, 11'h401, 16'h004a);
      rdchk(TGT_MEM, OP_LOW, 11'h402, 16'h004b);
      req_stream = 1'b1;
      rdchk(TGT_MEM, OP_WORD, 11'h000, 16'h4d4c);
      req_stream = 1'b0;
      xfer(TGT_MEM, OP_LOW, 1'b1, 11'h002, 16'h005a);
      rdchk(TGT_MEM, OP_LOW, 11'h002, 16'h005a);
      xfer(TGT_MEM, OP_LOW, 1'b1, 11'h001, 16'h003c);
      rdchk(TGT_MEM, OP_HIGH, 11'h000, 16'h003c);
      rdchk(TGT_MEM, OP_LOW, 11'h00d, 16'h003c);
      xfer(TGT_MEM, OP_WORD, 1'b1, 11'h000, 16'h1234);
      cmp(model_u.wr_word, 16'h1234);
      refuse(TGT_CMD, OP_WORD, 1'b0, 11'h000);
      fast_timing_req = 1'b1;
      for (int i = 0; i < 8; i++) begin
         {all_cards_fast, shared_master_slave, long_cable} = i[2:0];
         repeat (3) @(posedge mclk);
         #1 cmp({15'h0000, fast_active}, {15'h0000, i == 4});
      end
      power_request = 1'b0;
      ide_select = 1'b1;
      repeat (4) @(posedge mclk);
      // Unpowered card with the strap asked for: no power, output enable held low.
      #1 cmp({14'h0000, card_power_en, output_enable_n}, 16'h0000);
      power_request = 1'b1;
      rdchk(TGT_CMD, OP_WORD, 11'h000, 16'h4f4e);
      cmp({15'h0000, ide_mode}, 16'h0001);
      rdchk(TGT_DMA, OP_WORD, 11'h007, 16'h5150);
      refuse(TGT_MEM, OP_WORD, 1'b0, 11'h000);
      refuse(TGT_CTRL, OP_LOW, 1'b0, 11'h005);
      xfer(TGT_CMD, OP_LOW, 1'b1, 11'h003, 16'h00a5);
      rdchk(TGT_CMD, OP_LOW, 11'h003, 16'h00a5);
      xfer(TGT_CTRL, OP_LOW, 1'b1, 11'h006, 16'h000a);
      rdchk(TGT_CTRL, OP_LOW, 11'h006, 16'h000a);
      xfer(TGT_CMD, OP_LOW, 1'b1, 11'h001, {8'h00, `FEAT_8BIT_ON});
      xfer(TGT_CMD, OP_LOW, 1'b1, 11'h007, {8'h00, `CMD_SET_FEATURES});
      cmp({15'h0000, eight_bit_mode}, 16'h0001);
      rdchk(TGT_DMA, OP_WORD, 11'h000, 16'h0052);
      card_present = 1'b0;
      repeat (6) @(posedge mclk);
      #1 card_present = 1'b1;
      repeat (6) @(posedge mclk);
      #1 cmp({14'h0000, ide_mode, eight_bit_mode}, 16'h0000);
      end_of_test();
   end
endmodule
